// ===== bench/key_matrix_model.sv
`timescale 1ns/100ps
`default_nettype none
// passive switch matrix, four input lines by twenty pads
module key_matrix_model (
   input wire logic [79:0] pressed,
   input wire logic [19:0] pad_out,
   input wire logic [19:0] pad_oe_n,
   output logic [3:0] scan_input_line
);
   // series resistors keep pads apart, so a line sees the or of its closed keys;
   // a line with no closed key falls to its pull-down
   always_comb begin
      scan_input_line = 4'h0;
      for (int r = 0; r < 4; r++) begin
         for (int c = 0; c < 20; c++) begin
            if (pressed[r * 20 + c] && !pad_oe_n[c] && pad_out[c]) begin
               scan_input_line[r] = 1'b1;
            end
         end
      end
   end
endmodule // key_matrix_model
`default_nettype wire

// ===== bench/keyboard_matrix_scanner_bench.sv
`timescale 1ns/100ps
`default_nettype none
module keyboard_matrix_scanner_bench;
   import kbd_scan_pkg::*;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   reg_req_s req = '0;
   logic [7:0] rdata;
   logic irq;
   logic ks_en = 1'b0;
   logic [1:0] pw_opt = 2'h0;
   logic [19:0] seg = 20'hA5A5A;
   logic [3:0] sin;
   logic [19:0] sout;
   logic [19:0] soe_n;
   logic [79:0] keys = '0;
   int num_errors = 0;
   int checks_done = 0;
   int cycles = 0;
   int n;

   // 40 MHz system clock
   initial begin
      forever #12.5 sys_clk = ~sys_clk;
   end

   keyboard_matrix_scanner dut_u (.sys_clk(sys_clk), .rst(rst), .req(req), .rdata(rdata),
      .irq(irq), .keyscan_enable_option(ks_en), .scan_pulse_width_option(pw_opt),
      .seg_data(seg), .scan_input_line(sin), .scan_output_line(sout),
      .scan_output_oe_n(soe_n));
   key_matrix_model mat_u (.pressed(keys), .pad_out(sout), .pad_oe_n(soe_n),
      .scan_input_line(sin));

   task automatic chk(input logic [19:0] got, input logic [19:0] exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic finish_test();
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // options change only under reset, as a build choice would
   task automatic do_reset(input logic en, input logic [1:0] opt);
      @(posedge sys_clk);
      rst <= 1'b1;
      ks_en <= en;
      pw_opt <= opt;
      repeat (4) @(posedge sys_clk);
      rst <= 1'b0;
      // the release edge still resets; pads follow only at the next edge
      @(posedge sys_clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge sys_clk);
      req.wr <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge sys_clk);
      req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge sys_clk);
      req.rd <= 1'b0;
      #1 chk({12'h000, rdata}, {12'h000, exp});
   endtask

   // bounded wait for pad c to start or end its scan pulse;
   // segment slots drive every pad, so the whole enable word is matched
   task automatic wait_line(input int c, input logic lvl);
      n = 0;
      while (((sout[c] === 1'b1) && (soe_n === ~(20'h00001 << c))) != lvl) begin
         @(negedge sys_clk);
         n++;
         if (n > 40000) begin
            num_errors++;
            finish_test();
         end
      end
   endtask

   // key registers settle a few cycles after the last pad's pulse
   task automatic wait_frame();
      wait_line(19, 1'b1);
      wait_line(19, 1'b0);
      repeat (8) @(negedge sys_clk);
   endtask

   // hang guard, only some 12000 cycles above the planned run length of about 88000
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 100000) begin
         num_errors++;
         finish_test();
      end
   end

   initial begin
      keys <= 80'h1 << 20;
      do_reset(1'b0, 2'h0);
      n = 0;
      repeat (1300) begin
         @(negedge sys_clk);
         if (soe_n !== 20'h0 || sout !== seg) n++;
      end
      chk(20'(n), 20'h0);
      rd(8'h22, 8'h00);
      $display("scan off test done");
      for (int o = 3; o >= 0; o--) begin
         do_reset(1'b1, o[1:0]);
         repeat (10) @(negedge sys_clk);
         chk(soe_n, 20'h0);
         chk(sout, seg);
         wait_line(0, 1'b1);
         chk(soe_n, 20'hFFFFE);
         n = 0;
         while (sout[0] === 1'b1 && soe_n[0] === 1'b0 && n < 3000) begin
            @(negedge sys_clk);
            n++;
         end
         chk(20'(n), 20'((o + 1) * 611 + 1));
      end
      wait_line(1, 1'b1);
      chk(soe_n, 20'hFFFFD);
      $display("pulse width test done");
      @(posedge sys_clk);
      keys <= (80'h1 << 20) | (80'h1 << 79);
      do_reset(1'b1, 2'h0);
      wr(8'h26, 8'h03);
      rd(8'h26, 8'h03);
      wait_frame();
      rd(8'h22, 8'hA0);
      rd(8'h23, 8'hF3);
      rd(8'h24, 8'h01);
      chk({19'h0, irq}, 20'h1);
      wr(8'h25, 8'h01);
      // second key let go: its register falls to the no-key code
      keys <= 80'h1 << 20;
      rd(8'h24, 8'h00);
      chk({19'h0, irq}, 20'h0);
      wait_frame();
      rd(8'h22, 8'h20);
      rd(8'h23, 8'h00);
      rd(8'h24, 8'h02);
      chk({19'h0, irq}, 20'h1);
      $display("two key and repeat test done");
      @(posedge sys_clk);
      keys <= (80'h1 << 5) | (80'h1 << 47) | (80'h1 << 67);
      wr(8'h26, 8'h02);
      wr(8'h25, 8'h02);
      wait_frame();
      rd(8'h22, 8'h85);
      rd(8'h23, 8'hC7);
      chk({19'h0, irq}, 20'h0);
      rd(8'h24, 8'h01);
      wr(8'h22, 8'h00);
      rd(8'h22, 8'h85);
      rd(8'h30, 8'h00);
      $display("third key and mask test done");
      finish_test();
   end
endmodule // keyboard_matrix_scanner_bench
`default_nettype wire

// ===== common/kbd_scan_map.svh
`ifndef KBD_SCAN_MAP_SVH
`define KBD_SCAN_MAP_SVH

// register offsets
`define KBD_OFS_FIRST_KEY 8'h22
`define KBD_OFS_SECOND_KEY 8'h23
`define KBD_OFS_STATUS 8'h24
`define KBD_OFS_CLEAR 8'h25
`define KBD_OFS_ENABLE 8'h26

// key code layout
`define KBD_CODE_VALID_BIT 7
`define KBD_ROW_MSB 6
`define KBD_ROW_LSB 5
`define KBD_COL_MSB 4
`define KBD_KEY_RESET 8'h00
`define KBD_NO_KEY 8'h00

// matrix size
`define KBD_NUM_ROWS 4
`define KBD_NUM_COLS 20
`define KBD_LAST_COL 5'h13
`define KBD_LAST_ROW 2'h3

// status / enable bit positions and reset values
`define KBD_EV_PRESS 0
`define KBD_EV_RELEASE 1
`define KBD_STATUS_RESET 2'h0
`define KBD_ENABLE_RESET 2'h0

// timing: slow clock and system clock rates in Hz
`define KBD_SCK_HZ 32768
`define KBD_SYS_HZ 40000000
// half a slow-clock period in system cycles, rounded up
`define KBD_HALF_SCK_CYCLES ((`KBD_SYS_HZ + 2 * `KBD_SCK_HZ - 1) / (2 * `KBD_SCK_HZ))

`endif

// ===== common/kbd_scan_pkg.sv
package kbd_scan_pkg;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_SEG,
      ST_SCAN,
      ST_CHECK,
      ST_FRAME
   } phase_e;

   // register port request
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } reg_req_s;

   typedef struct packed {
      phase_e st;
      logic [4:0] col;
      logic [1:0] row;
      logic [3:0] hits;
      logic [1:0] found;
      logic [7:0] cand0;
      logic [7:0] cand1;
      logic [7:0] first_pressed_key;
      logic [7:0] second_pressed_key;
      logic [1:0] status;
      logic [1:0] enable;
      logic [7:0] rdata;
      logic run;
      logic [19:0] pad_out;
      logic [19:0] pad_oe_n;
   } scan_state_s;

   typedef struct packed {
      logic [11:0] cnt;
   } timer_state_s;

endpackage

// ===== verilog/keyboard_matrix_scanner.sv
`timescale 1ns/100ps
`default_nettype none
`include "kbd_scan_map.svh"

module keyboard_matrix_scanner (
   input wire logic sys_clk,
   input wire logic rst,
   input wire kbd_scan_pkg::reg_req_s req,
   output logic [7:0] rdata,
   output logic irq,
   input wire logic keyscan_enable_option,
   input wire logic [1:0] scan_pulse_width_option,
   input wire logic [19:0] seg_data,
   input wire logic [3:0] scan_input_line,
   output logic [19:0] scan_output_line,
   output logic [19:0] scan_output_oe_n
);
   import kbd_scan_pkg::*;

   scan_state_s r;
   scan_state_s next_r;
   logic slot_done;
   logic [7:0] code;

   // the slot timer measures both the segment slot and the scan pulse
   scan_pulse_timer slot_timer (
      .sys_clk(sys_clk),
      .rst(rst),
      .run(r.run),
      .width_opt(scan_pulse_width_option),
      .done(slot_done)
   );

   // location code of the key under test
   assign code = {1'b1, r.row, r.col};

   // new register value for one slot at frame end
   function automatic logic [7:0] settle_key(input logic [7:0] prev, input logic [7:0] cand,
                                            input logic seen);
      logic [7:0] res;
      res = `KBD_NO_KEY;
      if (seen) begin
         if (prev != `KBD_NO_KEY && prev[6:0] == cand[6:0]) begin
            res = {1'b0, cand[6:0]};
         end else begin
            res = cand;
         end
      end
      return res;
   endfunction

   // sequencing, key capture and register port
   always_comb begin
      next_r = r;
      next_r.rdata = 8'h00;
      unique case (r.st)
         ST_IDLE: begin
            next_r.run = 1'b0;
            if (keyscan_enable_option) begin
               next_r.st = ST_SEG;
               next_r.col = 5'h00;
               next_r.found = 2'h0;
            end
         end
         ST_SEG: begin
            // segment data owns the pads for one slot before each scan pulse
            next_r.run = !slot_done;
            if (slot_done) begin
               next_r.st = ST_SCAN;
            end
         end
         ST_SCAN: begin
            next_r.run = !slot_done;
            if (slot_done) begin
               next_r.hits = scan_input_line;
               next_r.row = 2'h0;
               next_r.st = ST_CHECK;
            end
         end
         ST_CHECK: begin
            // a key beyond the second is dropped for this scan
            if (r.hits[r.row]) begin
               if (r.found == 2'h0) begin
                  next_r.cand0 = code;
                  next_r.found = 2'h1;
               end else if (r.found == 2'h1) begin
                  next_r.cand1 = code;
                  next_r.found = 2'h2;
               end
            end
            next_r.row = r.row + 2'h1;
            if (r.row == `KBD_LAST_ROW) begin
               if (r.col == `KBD_LAST_COL) begin
                  next_r.col = 5'h00;
                  next_r.st = ST_FRAME;
               end else begin
                  next_r.col = r.col + 5'h01;
                  next_r.st = ST_SEG;
               end
            end
         end
         ST_FRAME: begin
            next_r.first_pressed_key = settle_key(r.first_pressed_key, r.cand0,
                                                  r.found != 2'h0);
            next_r.second_pressed_key = settle_key(r.second_pressed_key, r.cand1,
                                                   r.found == 2'h2);
            next_r.found = 2'h0;
            next_r.st = keyscan_enable_option ? ST_SEG : ST_IDLE;
         end
      endcase

      // option off: keys forgotten, pads stay segments
      if (!keyscan_enable_option) begin
         next_r.st = ST_IDLE;
         next_r.run = 1'b0;
         next_r.first_pressed_key = `KBD_NO_KEY;
         next_r.second_pressed_key = `KBD_NO_KEY;
      end

      // sticky events: a fresh event wins over a clear in the same cycle
      if (req.wr && req.addr == `KBD_OFS_CLEAR) begin
         next_r.status = r.status & ~req.wdata[1:0];
      end
      if (r.st == ST_FRAME) begin
         if ((r.found != 2'h0 && next_r.first_pressed_key[7])
             || (r.found == 2'h2 && next_r.second_pressed_key[7])) begin
            next_r.status[`KBD_EV_PRESS] = 1'b1;
         end
         if ((r.first_pressed_key != `KBD_NO_KEY && next_r.first_pressed_key == `KBD_NO_KEY)
             || (r.second_pressed_key != `KBD_NO_KEY
                 && next_r.second_pressed_key == `KBD_NO_KEY)) begin
            next_r.status[`KBD_EV_RELEASE] = 1'b1;
         end
      end
      if (req.wr && req.addr == `KBD_OFS_ENABLE) begin
         next_r.enable = req.wdata[1:0];
      end

      // read data one cycle later; unmapped and write-only read zero
      if (req.rd) begin
         unique case (req.addr)
            `KBD_OFS_FIRST_KEY: next_r.rdata = r.first_pressed_key;
            `KBD_OFS_SECOND_KEY: next_r.rdata = r.second_pressed_key;
            `KBD_OFS_STATUS: next_r.rdata = {6'h00, r.status};
            `KBD_OFS_ENABLE: next_r.rdata = {6'h00, r.enable};
            default: next_r.rdata = 8'h00;
         endcase
      end

      // pads: one line pulsed high during scan, others released; else segments
      next_r.pad_out = seg_data;
      next_r.pad_oe_n = 20'h00000;
      if (next_r.st == ST_SCAN) begin
         next_r.pad_out = 20'h00001 << next_r.col;
         next_r.pad_oe_n = ~(20'h00001 << next_r.col);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         r.st <= ST_IDLE;
         r.col <= 5'h00;
         r.row <= 2'h0;
         r.hits <= 4'h0;
         r.found <= 2'h0;
         r.cand0 <= `KBD_NO_KEY;
         r.cand1 <= `KBD_NO_KEY;
         r.first_pressed_key <= `KBD_KEY_RESET;
         r.second_pressed_key <= `KBD_KEY_RESET;
         r.status <= `KBD_STATUS_RESET;
         r.enable <= `KBD_ENABLE_RESET;
         r.rdata <= 8'h00;
         r.run <= 1'b0;
         r.pad_out <= 20'h00000;
         r.pad_oe_n <= 20'h00000;
      end else begin
         r <= next_r;
      end
   end

   assign rdata = r.rdata;
   assign irq = |(r.status & r.enable);
   assign scan_output_line = r.pad_out;
   assign scan_output_oe_n = r.pad_oe_n;

   // helper: cycles spent in the current scan slot
   logic [12:0] scan_cyc;
   logic [12:0] scan_target;
   assign scan_target = 13'({10'h000, scan_pulse_width_option} + 12'h001)
                        * 13'(`KBD_HALF_SCK_CYCLES);
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         scan_cyc <= 13'h0000;
      end else begin
         scan_cyc <= (r.st == ST_SCAN) ? scan_cyc + 13'h0001 : 13'h0000;
      end
   end

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   a_one_line_scan: assert property (
      r.st == ST_SCAN |-> $onehot(~scan_output_oe_n) && scan_output_line == ~scan_output_oe_n)
      else $error("scan slot must drive exactly one line");
   a_col_range: assert property (r.col <= `KBD_LAST_COL)
      else $error("scan column out of range");
   a_col_advance: assert property (
      r.st == ST_CHECK && r.row == `KBD_LAST_ROW && keyscan_enable_option
      |=> r.col == (($past(r.col) == `KBD_LAST_COL) ? 5'h00 : $past(r.col) + 5'h01))
      else $error("scan column did not advance or wrap");
   a_code_format: assert property (
      r.first_pressed_key != `KBD_NO_KEY |-> r.first_pressed_key[4:0] <= `KBD_LAST_COL)
      else $error("first key code malformed");
   a_second_after_first: assert property (
      r.second_pressed_key != `KBD_NO_KEY |-> r.first_pressed_key != `KBD_NO_KEY)
      else $error("second key reported without a first");
   a_repeat_clear: assert property (
      r.st == ST_FRAME && keyscan_enable_option && r.found != 2'h0
      && r.first_pressed_key != `KBD_NO_KEY && r.first_pressed_key[6:0] == r.cand0[6:0]
      |=> r.first_pressed_key == {1'b0, $past(r.cand0[6:0])})
      else $error("repeat indicator not cleared");
   a_option_off: assert property (
      !keyscan_enable_option |=> scan_output_oe_n == 20'h00000
      && scan_output_line == $past(seg_data) ##1 r.first_pressed_key == `KBD_NO_KEY)
      else $error("pads must be segment only when scanning is off");
   a_pulse_width: assert property (
      $past(r.st) == ST_SCAN && r.st == ST_CHECK |-> $past(scan_cyc) == $past(scan_target))
      else $error("scan pulse width wrong");
   a_seg_between: assert property (
      r.st == ST_CHECK && r.row == `KBD_LAST_ROW && r.col != `KBD_LAST_COL
      && keyscan_enable_option |=> r.st == ST_SEG && scan_output_oe_n == 20'h00000)
      else $error("segment slot missing between scan pulses");

   c_two_keys: cover property (r.st == ST_FRAME && r.found == 2'h2);
   c_repeat: cover property (r.first_pressed_key[7] ##[1:1000] r.first_pressed_key != 8'h00
                             && !r.first_pressed_key[7]);
   c_wrap: cover property (r.st == ST_FRAME ##1 r.st == ST_SEG && r.col == 5'h00);
   c_irq: cover property (irq);

endmodule // keyboard_matrix_scanner

`default_nettype wire

// ===== verilog/scan_pulse_timer.sv
`timescale 1ns/100ps
`default_nettype none
`include "kbd_scan_map.svh"

// counts a slot of (width option + 1) half slow-clock periods while run is high
module scan_pulse_timer (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic run,
   input wire logic [1:0] width_opt,
   output logic done
);
   import kbd_scan_pkg::*;

   timer_state_s r;
   timer_state_s next_r;
   logic [11:0] target;

   // 00..11 selects 1..4 half periods
   assign target = 12'({10'h000, width_opt} + 12'h001) * 12'(`KBD_HALF_SCK_CYCLES);
   assign done = run && (r.cnt == target - 12'h001);

   // counter restarts whenever run drops, so each slot is timed afresh
   always_comb begin
      next_r = r;
      if (!run || done) begin
         next_r.cnt = 12'h000;
      end else begin
         next_r.cnt = r.cnt + 12'h001;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

endmodule // scan_pulse_timer

`default_nettype wire
